// ===== sample_serial_pkg.sv
// Shared types, timing constants and lane mapping for the sample serial link.
package sample_serial_pkg;

   // Clock and link clock timing.
   localparam int CLK_PERIOD_PS = 8000;
   localparam int LINK_PERIOD_PS = 128000;
   localparam int SE_MAX_CLK_KHZ = 80000;
   localparam int DIFF_MAX_CLK_KHZ = 491520;
   localparam int SE_MIN_PERIOD_PS = (1000000000 + SE_MAX_CLK_KHZ - 1)
      / SE_MAX_CLK_KHZ;
   localparam int DIFF_MIN_PERIOD_PS = (1000000000 + DIFF_MAX_CLK_KHZ - 1)
      / DIFF_MAX_CLK_KHZ;
   localparam int NOM_HALF = (LINK_PERIOD_PS / 2 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int MIN_HALF = (SE_MIN_PERIOD_PS / 2 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam logic [3:0] LINK_HALF =
      4'(NOM_HALF > MIN_HALF ? NOM_HALF : MIN_HALF);
   localparam logic [3:0] LINK_LAST = 4'(LINK_HALF - 4'h1);
   localparam logic [3:0] LINK_MID = 4'(LINK_HALF >> 1);

   // Pad delay cells.
   localparam logic [2:0] DELAY_MAX_STEP = 3'h7;
   localparam int DELAY_STEP_PS_DIFF = 90;
   localparam int DELAY_STEP_PS_SE = 170;

   // Sample word layout: I in the upper half, Q in the lower half.
   localparam int I_BASE = 16;
   localparam int Q_BASE = 0;
   localparam logic [31:0] EXT12_MASK = 32'hFFF0_FFF0;

   // Bit positions of the synchronised pin vector.
   localparam int PIN_CLK = 5;
   localparam int PIN_STROBE = 4;

   typedef enum logic [3:0] {
      MODE_SE1 = 4'b0001,
      MODE_SE4 = 4'b0010,
      MODE_DIFF1 = 4'b0100,
      MODE_DIFF2 = 4'b1000
   } laneMode_e;

   typedef enum logic [2:0] {
      FMT_IQ = 3'b001,
      FMT_SYM16 = 3'b010,
      FMT_SYM8 = 3'b100
   } dataFmt_e;

   typedef struct packed {
      laneMode_e mode;
      dataFmt_e fmt;
      logic ddr;
      logic width12;
      logic qFirst;
      logic lsbFirst;
      logic strobeLevel;
   } chanCfg_s;

   // Sending end of one channel, with a one-word holding register.
   typedef struct packed {
      chanCfg_s cfg;
      logic [3:0] div;
      logic lclk;
      logic strobe;
      logic [3:0] data;
      logic [5:0] k;
      logic busy;
      logic [31:0] word;
      logic [31:0] hold;
      logic full;
      logic ready;
      logic err;
   } serEng_s;

   // Receiving end of one channel.
   typedef struct packed {
      chanCfg_s cfg;
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic [5:0] prev;
      logic lastStrb;
      logic [5:0] k;
      logic busy;
      logic [31:0] word;
      logic [31:0] outWord;
      logic outValid;
      logic err;
   } desEng_s;

   function automatic logic isDiff(chanCfg_s c);
      return c.mode == MODE_DIFF1 || c.mode == MODE_DIFF2;
   endfunction

   function automatic logic isDdr(chanCfg_s c);
      return c.ddr || isDiff(c);
   endfunction

   function automatic logic legal(chanCfg_s c);
      logic ok;
      ok = 1'b1;
      if ((c.mode == MODE_SE4 || isDiff(c)) && c.fmt != FMT_IQ) ok = 1'b0;
      if (c.width12 && c.mode != MODE_DIFF2) ok = 1'b0;
      return ok;
   endfunction

   function automatic logic [2:0] laneCount(chanCfg_s c);
      case (c.mode)
         MODE_SE4: return 3'h4;
         MODE_DIFF2: return 3'h2;
         default: return 3'h1;
      endcase
   endfunction

   function automatic logic [5:0] bitsPerLane(chanCfg_s c);
      case (c.mode)
         MODE_SE4: return 6'h08;
         MODE_DIFF2: return c.width12 ? 6'h0c : 6'h10;
         default: begin
            case (c.fmt)
               FMT_SYM16: return 6'h10;
               FMT_SYM8: return 6'h08;
               default: return 6'h20;
            endcase
         end
      endcase
   endfunction

   // Word bit carried as the k-th bit on a lane.
   function automatic logic [4:0] bitPos(chanCfg_s c, int lane, int k);
      int b;
      int w;
      int n;
      int p;
      b = 0;
      w = c.width12 ? 12 : 16;
      n = int'(bitsPerLane(c));
      p = 0;
      case (c.mode)
         MODE_SE4: begin
            b = (lane < 2 ? I_BASE : Q_BASE) + (lane % 2) * 8;
            p = b + (c.lsbFirst ? k : 7 - k);
         end
         MODE_DIFF2: begin
            b = lane == 0 ? I_BASE : Q_BASE;
            p = b + (c.lsbFirst ? 16 - w + k : 15 - k);
         end
         default: begin
            if (c.fmt == FMT_IQ) begin
               b = ((k < 16) != c.qFirst) ? I_BASE : Q_BASE;
               p = b + (c.lsbFirst ? k % 16 : 15 - k % 16);
            end else begin
               p = c.lsbFirst ? k : n - 1 - k;
            end
         end
      endcase
      return 5'(p);
   endfunction

endpackage

// ===== sample_serial_if.sv
// Link wires between the transceiver end and the baseband end.
`timescale 1ns/1ps
interface sample_serial_if;
   logic [1:0] rxClk;
   logic [1:0] rxStrobe;
   logic [1:0][3:0] rxData;
   logic [1:0] txClk;
   logic [1:0] txStrobe;
   logic [1:0][3:0] txData;

   modport device (
      output rxClk, rxStrobe, rxData,
      input txClk, txStrobe, txData
   );

   modport host (
      input rxClk, rxStrobe, rxData,
      output txClk, txStrobe, txData
   );
endinterface

// ===== sample_serial_device.sv
// Transceiver end: sends two receive channels, recovers two transmit ones.
`timescale 1ns/1ps
// Functional notes
// - Two receive, two transmit channels, independently configured.
// - Each channel drives one pad variant only.
// - Single-ended port: SDR or DDR, clock limited.
// - One lane carries whole word, 32 for I/Q.
// - Four lanes only for 16-bit I/Q.
// - Four lanes carry one byte each.
// - Differential port always DDR, clock limited.
// - Differential one lane carries 32-bit I/Q.
// - Differential two lanes split I, Q; 16/12.
// - 12-bit mode rounds receive, extends transmit samples.
// - Per-channel pad delay step zero to seven.
// - Strobe marks first bit of each word.
// - I/Q order and bit order selectable.
// - DDR carries one bit per edge.
module sample_serial_device (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Link
   sample_serial_if.device link,
   // Receive samples to send
   input wire logic [1:0] rxValid,
   input wire logic [1:0][31:0] rxWord,
   output logic [1:0] rxReady,
   // Transmit samples recovered
   output logic [1:0] txValid,
   output logic [1:0][31:0] txWord,
   // Channel configuration
   input wire logic [1:0] rxEnable,
   input wire logic [1:0] txEnable,
   input wire sample_serial_pkg::chanCfg_s [1:0] rxCfg,
   input wire sample_serial_pkg::chanCfg_s [1:0] txCfg,
   input wire logic [3:0][2:0] delayStep,
   // Pad control and status
   output logic [3:0] seActive,
   output logic [3:0] diffActive,
   output logic [3:0][2:0] padDelay,
   output logic [3:0] cfgError
);

   typedef struct packed {
      sample_serial_pkg::serEng_s [1:0] rx;
      sample_serial_pkg::desEng_s [1:0] tx;
      logic [3:0] seAct;
      logic [3:0] diffAct;
      logic [3:0][2:0] delay;
   } devState_s;

   devState_s s;
   devState_s next_s;

   // Rounds a component to 12 bits, kept left aligned, with saturation.
   function automatic logic [15:0] round12(logic [15:0] x);
      if ($signed(x) > $signed(16'h7FF7)) return 16'h7FF0;
      return 16'(x + 16'h0008) & 16'hFFF0;
   endfunction

   always_comb begin
      logic [5:0] n;
      logic [2:0] nl;
      logic [31:0] w;
      logic [5:0] kk;
      logic st;
      logic upd;
      logic smp;
      sample_serial_pkg::chanCfg_s c;
      n = 6'h00;
      nl = 3'h0;
      w = 32'h0000_0000;
      kk = 6'h00;
      st = 1'b0;
      upd = 1'b0;
      smp = 1'b0;
      c = s.rx[0].cfg;
      next_s = s;
      for (int ch = 0; ch < 2; ch++) begin
         // Sending side of receive channel ch.
         if (!rxEnable[ch]) begin
            next_s.rx[ch] = '0;
            next_s.rx[ch].cfg = rxCfg[ch];
         end else if (!sample_serial_pkg::legal(s.rx[ch].cfg)) begin
            next_s.rx[ch].err = 1'b1;
         end else begin
            c = s.rx[ch].cfg;
            n = sample_serial_pkg::bitsPerLane(c);
            nl = sample_serial_pkg::laneCount(c);
            next_s.rx[ch].err = 1'b0;
            if (s.rx[ch].div == sample_serial_pkg::LINK_LAST) begin
               next_s.rx[ch].div = 4'h0;
               next_s.rx[ch].lclk = !s.rx[ch].lclk;
            end else begin
               next_s.rx[ch].div = 4'(s.rx[ch].div + 4'h1);
            end
            upd = s.rx[ch].div == sample_serial_pkg::LINK_MID
               && (sample_serial_pkg::isDdr(c) || s.rx[ch].lclk);
            if (rxValid[ch] && s.rx[ch].ready) begin
               next_s.rx[ch].full = 1'b1;
               next_s.rx[ch].hold = rxWord[ch];
               if (c.mode == sample_serial_pkg::MODE_DIFF2 && c.width12) begin
                  next_s.rx[ch].hold = {round12(rxWord[ch][31:16]),
                     round12(rxWord[ch][15:0])};
               end
            end
            if (upd) begin
               if (s.rx[ch].busy && s.rx[ch].k != 6'(n - 6'h01)) begin
                  next_s.rx[ch].k = 6'(s.rx[ch].k + 6'h01);
               end else if (s.rx[ch].full) begin
                  next_s.rx[ch].word = s.rx[ch].hold;
                  next_s.rx[ch].k = 6'h00;
                  next_s.rx[ch].busy = 1'b1;
                  next_s.rx[ch].full = 1'b0;
               end else begin
                  next_s.rx[ch].busy = 1'b0;
               end
               kk = next_s.rx[ch].k;
               w = next_s.rx[ch].word;
               for (int l = 0; l < 4; l++) begin
                  next_s.rx[ch].data[l] = next_s.rx[ch].busy && l < int'(nl)
                     && w[sample_serial_pkg::bitPos(c, l, int'(kk))];
               end
               next_s.rx[ch].strobe = next_s.rx[ch].busy
                  && (c.strobeLevel ? kk < (n >> 1) : kk == 6'h00);
            end
            next_s.rx[ch].ready = !next_s.rx[ch].full;
         end

         // Receiving side of transmit channel ch; pins pass two flops.
         next_s.tx[ch].sync1 = {link.txClk[ch], link.txStrobe[ch],
            link.txData[ch]};
         next_s.tx[ch].sync2 = s.tx[ch].sync1;
         next_s.tx[ch].prev = s.tx[ch].sync2;
         next_s.tx[ch].outValid = 1'b0;
         if (!txEnable[ch]) begin
            next_s.tx[ch].cfg = txCfg[ch];
            next_s.tx[ch].busy = 1'b0;
            next_s.tx[ch].lastStrb = 1'b0;
            next_s.tx[ch].err = 1'b0;
         end else if (!sample_serial_pkg::legal(s.tx[ch].cfg)) begin
            next_s.tx[ch].err = 1'b1;
         end else begin
            c = s.tx[ch].cfg;
            n = sample_serial_pkg::bitsPerLane(c);
            nl = sample_serial_pkg::laneCount(c);
            next_s.tx[ch].err = 1'b0;
            smp = sample_serial_pkg::isDdr(c)
               ? s.tx[ch].sync2[5] != s.tx[ch].prev[5]
               : s.tx[ch].sync2[5] && !s.tx[ch].prev[5];
            if (smp) begin
               st = s.tx[ch].sync2[4] && !s.tx[ch].lastStrb;
               next_s.tx[ch].lastStrb = s.tx[ch].sync2[4];
               if (st || s.tx[ch].busy) begin
                  w = st ? 32'h0000_0000 : s.tx[ch].word;
                  kk = st ? 6'h00 : s.tx[ch].k;
                  for (int l = 0; l < 4; l++) begin
                     if (l < int'(nl)) begin
                        w[sample_serial_pkg::bitPos(c, l, int'(kk))] =
                           s.tx[ch].sync2[l];
                     end
                  end
                  if (kk == 6'(n - 6'h01)) begin
                     next_s.tx[ch].busy = 1'b0;
                     next_s.tx[ch].outValid = 1'b1;
                     next_s.tx[ch].outWord = w;
                     if (c.mode == sample_serial_pkg::MODE_DIFF2
                        && c.width12) begin
                        next_s.tx[ch].outWord =
                           w & sample_serial_pkg::EXT12_MASK;
                     end
                  end else begin
                     next_s.tx[ch].busy = 1'b1;
                     next_s.tx[ch].k = 6'(kk + 6'h01);
                     next_s.tx[ch].word = w;
                  end
               end
            end
         end
      end

      // Pad variant and delay per channel: rx0, rx1, tx0, tx1.
      for (int i = 0; i < 4; i++) begin
         c = i < 2 ? next_s.rx[i % 2].cfg : next_s.tx[i % 2].cfg;
         st = i < 2 ? rxEnable[i % 2] : txEnable[i % 2];
         next_s.seAct[i] = st && !sample_serial_pkg::isDiff(c);
         next_s.diffAct[i] = st && sample_serial_pkg::isDiff(c);
         next_s.delay[i] = delayStep[i];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign link.rxClk = {s.rx[1].lclk, s.rx[0].lclk};
   assign link.rxStrobe = {s.rx[1].strobe, s.rx[0].strobe};
   assign link.rxData = {s.rx[1].data, s.rx[0].data};
   assign rxReady = {s.rx[1].ready, s.rx[0].ready};
   assign txValid = {s.tx[1].outValid, s.tx[0].outValid};
   assign txWord = {s.tx[1].outWord, s.tx[0].outWord};
   assign seActive = s.seAct;
   assign diffActive = s.diffAct;
   assign padDelay = s.delay;
   assign cfgError = {s.tx[1].err, s.tx[0].err, s.rx[1].err, s.rx[0].err};

endmodule

// ===== sample_serial_host.sv
// Baseband end: sends two transmit channels, recovers two receive ones.
`timescale 1ns/1ps
module sample_serial_host (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Link
   sample_serial_if.host link,
   // Transmit samples to send
   input wire logic [1:0] txValid,
   input wire logic [1:0][31:0] txWord,
   output logic [1:0] txReady,
   // Receive samples recovered
   output logic [1:0] rxValid,
   output logic [1:0][31:0] rxWord,
   // Channel configuration
   input wire logic [1:0] rxEnable,
   input wire logic [1:0] txEnable,
   input wire sample_serial_pkg::chanCfg_s [1:0] rxCfg,
   input wire sample_serial_pkg::chanCfg_s [1:0] txCfg,
   // Status
   output logic [3:0] cfgError
);

   typedef struct packed {
      sample_serial_pkg::serEng_s [1:0] tx;
      sample_serial_pkg::desEng_s [1:0] rx;
   } hostState_s;

   hostState_s s;
   hostState_s next_s;

   always_comb begin
      logic [5:0] n;
      logic [2:0] nl;
      logic [31:0] w;
      logic [5:0] kk;
      logic st;
      logic upd;
      logic smp;
      sample_serial_pkg::chanCfg_s c;
      n = 6'h00;
      nl = 3'h0;
      w = 32'h0000_0000;
      kk = 6'h00;
      st = 1'b0;
      upd = 1'b0;
      smp = 1'b0;
      c = s.tx[0].cfg;
      next_s = s;
      for (int ch = 0; ch < 2; ch++) begin
         // Sending side of transmit channel ch.
         if (!txEnable[ch]) begin
            next_s.tx[ch] = '0;
            next_s.tx[ch].cfg = txCfg[ch];
         end else if (!sample_serial_pkg::legal(s.tx[ch].cfg)) begin
            next_s.tx[ch].err = 1'b1;
         end else begin
            c = s.tx[ch].cfg;
            n = sample_serial_pkg::bitsPerLane(c);
            nl = sample_serial_pkg::laneCount(c);
            next_s.tx[ch].err = 1'b0;
            if (s.tx[ch].div == sample_serial_pkg::LINK_LAST) begin
               next_s.tx[ch].div = 4'h0;
               next_s.tx[ch].lclk = !s.tx[ch].lclk;
            end else begin
               next_s.tx[ch].div = 4'(s.tx[ch].div + 4'h1);
            end
            upd = s.tx[ch].div == sample_serial_pkg::LINK_MID
               && (sample_serial_pkg::isDdr(c) || s.tx[ch].lclk);
            if (txValid[ch] && s.tx[ch].ready) begin
               next_s.tx[ch].full = 1'b1;
               next_s.tx[ch].hold = txWord[ch];
            end
            if (upd) begin
               if (s.tx[ch].busy && s.tx[ch].k != 6'(n - 6'h01)) begin
                  next_s.tx[ch].k = 6'(s.tx[ch].k + 6'h01);
               end else if (s.tx[ch].full) begin
                  next_s.tx[ch].word = s.tx[ch].hold;
                  next_s.tx[ch].k = 6'h00;
                  next_s.tx[ch].busy = 1'b1;
                  next_s.tx[ch].full = 1'b0;
               end else begin
                  next_s.tx[ch].busy = 1'b0;
               end
               kk = next_s.tx[ch].k;
               w = next_s.tx[ch].word;
               for (int l = 0; l < 4; l++) begin
                  next_s.tx[ch].data[l] = next_s.tx[ch].busy && l < int'(nl)
                     && w[sample_serial_pkg::bitPos(c, l, int'(kk))];
               end
               next_s.tx[ch].strobe = next_s.tx[ch].busy
                  && (c.strobeLevel ? kk < (n >> 1) : kk == 6'h00);
            end
            next_s.tx[ch].ready = !next_s.tx[ch].full;
         end

         // Receiving side of receive channel ch; pins pass two flops.
         next_s.rx[ch].sync1 = {link.rxClk[ch], link.rxStrobe[ch],
            link.rxData[ch]};
         next_s.rx[ch].sync2 = s.rx[ch].sync1;
         next_s.rx[ch].prev = s.rx[ch].sync2;
         next_s.rx[ch].outValid = 1'b0;
         if (!rxEnable[ch]) begin
            next_s.rx[ch].cfg = rxCfg[ch];
            next_s.rx[ch].busy = 1'b0;
            next_s.rx[ch].lastStrb = 1'b0;
            next_s.rx[ch].err = 1'b0;
         end else if (!sample_serial_pkg::legal(s.rx[ch].cfg)) begin
            next_s.rx[ch].err = 1'b1;
         end else begin
            c = s.rx[ch].cfg;
            n = sample_serial_pkg::bitsPerLane(c);
            nl = sample_serial_pkg::laneCount(c);
            next_s.rx[ch].err = 1'b0;
            smp = sample_serial_pkg::isDdr(c)
               ? s.rx[ch].sync2[5] != s.rx[ch].prev[5]
               : s.rx[ch].sync2[5] && !s.rx[ch].prev[5];
            if (smp) begin
               st = s.rx[ch].sync2[4] && !s.rx[ch].lastStrb;
               next_s.rx[ch].lastStrb = s.rx[ch].sync2[4];
               if (st || s.rx[ch].busy) begin
                  w = st ? 32'h0000_0000 : s.rx[ch].word;
                  kk = st ? 6'h00 : s.rx[ch].k;
                  for (int l = 0; l < 4; l++) begin
                     if (l < int'(nl)) begin
                        w[sample_serial_pkg::bitPos(c, l, int'(kk))] =
                           s.rx[ch].sync2[l];
                     end
                  end
                  if (kk == 6'(n - 6'h01)) begin
                     next_s.rx[ch].busy = 1'b0;
                     next_s.rx[ch].outValid = 1'b1;
                     next_s.rx[ch].outWord = w;
                  end else begin
                     next_s.rx[ch].busy = 1'b1;
                     next_s.rx[ch].k = 6'(kk + 6'h01);
                     next_s.rx[ch].word = w;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign link.txClk = {s.tx[1].lclk, s.tx[0].lclk};
   assign link.txStrobe = {s.tx[1].strobe, s.tx[0].strobe};
   assign link.txData = {s.tx[1].data, s.tx[0].data};
   assign txReady = {s.tx[1].ready, s.tx[0].ready};
   assign rxValid = {s.rx[1].outValid, s.rx[0].outValid};
   assign rxWord = {s.rx[1].outWord, s.rx[0].outWord};
   assign cfgError = {s.tx[1].err, s.tx[0].err, s.rx[1].err, s.rx[0].err};

endmodule

// ===== sample_serial_properties.sv
// Link timing properties watched on the wires between both ends.
`timescale 1ns/1ps
module sample_serial_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Link wires
   input wire logic [1:0] rxClk,
   input wire logic [1:0] rxStrobe,
   input wire logic [1:0][3:0] rxData,
   input wire logic [1:0] txClk,
   input wire logic [1:0] txStrobe,
   input wire logic [1:0][3:0] txData
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // Each link clock phase lasts eight system clocks.
   rx_clk_high_a: assert property ($rose(rxClk[0]) |->
      rxClk[0] [*8] ##1 !rxClk[0]) else $error("rx clock high time");
   rx_clk_low_a: assert property ($fell(rxClk[1]) |->
      !rxClk[1] [*8] ##1 rxClk[1]) else $error("rx clock low time");
   tx_clk_high_a: assert property ($rose(txClk[0]) |->
      txClk[0] [*8] ##1 !txClk[0]) else $error("tx clock high time");
   tx_clk_low_a: assert property ($fell(txClk[1]) |->
      !txClk[1] [*8] ##1 txClk[1]) else $error("tx clock low time");
   // Data and strobe move only mid-phase, never near a clock edge.
   rx_data_hold_a: assert property ($changed(rxClk[0]) |->
      $stable(rxData[0]) [*3]) else $error("rx data moved at edge");
   rx_strobe_hold_a: assert property ($changed(rxClk[1]) |->
      $stable(rxStrobe[1]) [*3]) else $error("rx strobe moved");
   tx_data_hold_a: assert property ($changed(txClk[0]) |->
      $stable(txData[0]) [*3]) else $error("tx data moved at edge");
   tx_strobe_hold_a: assert property ($changed(txClk[1]) |->
      $stable(txStrobe[1]) [*3]) else $error("tx strobe moved");

   cover property ($rose(rxStrobe[0]));
   cover property ($rose(txStrobe[1]));
   cover property ($rose(rxData[1][3]));
endmodule

// ===== sample_serial_port_lane_formatter_bench.sv
// Bench joining both link ends, streaming words in every lane mode.
`timescale 1ns/1ps
module sample_serial_port_lane_formatter_bench;
   logic clk;
   logic arst_n;
   logic en;
   logic [3:0] inValid;
   logic [3:0][31:0] inWord;
   logic [3:0] ready;
   logic [3:0] outValid;
   logic [3:0][31:0] outWord;
   logic [3:0] seAct, diffAct, dErr, hErr;
   logic [3:0][2:0] dly;
   logic [3:0][2:0] padDly;
   sample_serial_pkg::chanCfg_s cfg;
   logic [31:0] expq[4][$];
   int errors, n_compared, cyc;
   logic [31:0] want;
   // Mode and format pairs; the last one is illegal.
   logic [6:0] mf[10] = '{7'h09, 7'h09, 7'h0a, 7'h0c, 7'h11, 7'h11, 7'h21,
      7'h41, 7'h41, 7'h14};

   sample_serial_if sample_serial_if_i();
   sample_serial_device sample_serial_device_i(.clk(clk), .arst_n(arst_n),
      .link(sample_serial_if_i), .rxValid(inValid[1:0]),
      .rxWord(inWord[1:0]), .rxReady(ready[1:0]), .txValid(outValid[3:2]),
      .txWord(outWord[3:2]), .rxEnable({en, en}), .txEnable({en, en}),
      .rxCfg({cfg, cfg}), .txCfg({cfg, cfg}), .delayStep(dly),
      .seActive(seAct), .diffActive(diffAct), .padDelay(padDly),
      .cfgError(dErr));
   sample_serial_host sample_serial_host_i(.clk(clk), .arst_n(arst_n),
      .link(sample_serial_if_i), .txValid(inValid[3:2]),
      .txWord(inWord[3:2]), .txReady(ready[3:2]), .rxValid(outValid[1:0]),
      .rxWord(outWord[1:0]), .rxEnable({en, en}), .txEnable({en, en}),
      .rxCfg({cfg, cfg}), .txCfg({cfg, cfg}), .cfgError(hErr));
   sample_serial_properties sample_serial_properties_i(.clk(clk),
      .arst_n(arst_n), .rxClk(sample_serial_if_i.rxClk),
      .rxStrobe(sample_serial_if_i.rxStrobe),
      .rxData(sample_serial_if_i.rxData), .txClk(sample_serial_if_i.txClk),
      .txStrobe(sample_serial_if_i.txStrobe),
      .txData(sample_serial_if_i.txData));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [15:0] rnd16(logic [15:0] h);
      if (h >= 16'h7ff8 && h <= 16'h7fff) return 16'h7ff0;
      return (h + 16'h0008) & 16'hfff0;
   endfunction

   function automatic logic [31:0] expWord(int c, logic [31:0] w);
      if (cfg.fmt == sample_serial_pkg::FMT_SYM16) return w & 32'h0000_ffff;
      if (cfg.fmt == sample_serial_pkg::FMT_SYM8) return w & 32'h0000_00ff;
      if (!cfg.width12) return w;
      if (c < 2) return {rnd16(w[31:16]), rnd16(w[15:0])};
      return w & 32'hfff0_fff0;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic send(input int c, input logic [31:0] w);
      int n;
      n = 0;
      @(negedge clk);
      while (ready[c] !== 1'b1 && n < 1200) begin
         @(negedge clk);
         n++;
      end
      if (n >= 1200) errors++;
      inValid[c] = 1'b1;
      inWord[c] = w;
      expq[c].push_back(expWord(c, w));
      @(negedge clk);
      inValid[c] = 1'b0;
   endtask

   // Two rounding corners, then a random word, on one channel.
   task automatic stream(input int c);
      for (int i = 0; i < 3; i++) begin
         send(c, i == 0 ? 32'h7ff8_fff9 : i == 1 ? 32'h8000_0007 : $urandom);
      end
   endtask

   task automatic run(input int id);
      int n;
      logic diff;
      @(negedge clk);
      arst_n = 1'b0;
      en = 1'b0;
      cfg = sample_serial_pkg::chanCfg_s'({mf[id], id[0], id == 8,
         3'($urandom)});
      dly = 12'($urandom);
      diff = cfg.mode[2] | cfg.mode[3];
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      en = 1'b1;
      repeat (3) @(negedge clk);
      if (id == 9) begin
         chk(dErr, 4'hf);
         chk(hErr, 4'hf);
         chk(ready, 4'h0);
      end else begin
         chk(dErr | hErr, 4'h0);
         for (int i = 0; i < 4; i++) begin
            chk(padDly[i], dly[i]);
            chk(diffAct[i], diff);
            chk(seAct[i], !diff);
         end
         fork
            stream(0);
            stream(1);
            stream(2);
            stream(3);
         join
         n = 0;
         while (expq[0].size() + expq[1].size() + expq[2].size()
               + expq[3].size() > 0 && n < 1500) begin
            @(negedge clk);
            n++;
         end
         for (int c = 0; c < 4; c++) begin
            chk(expq[c].size(), 0);
            expq[c].delete();
         end
      end
      $display("test %0d done", id);
   endtask

   always @(negedge clk) begin
      for (int c = 0; c < 4; c++) begin
         if (outValid[c] === 1'b1 && arst_n) begin
            want = expq[c].size() ? expq[c].pop_front() : 32'hxxxx_xxxx;
            chk(outWord[c], want);
         end
      end
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         finish_test();
      end
   end

   initial begin
      void'($urandom(65224));
      arst_n = 1'b0;
      en = 1'b0;
      inValid = '0;
      inWord = '0;
      cfg = '0;
      dly = '0;
      errors = 0;
      n_compared = 0;
      cyc = 0;
      for (int i = 0; i < 10; i++) begin
         run(i);
      end
      finish_test();
   end
endmodule
